// File: logic/dpec_top.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps

module dpec_top
   import dpec_pkg::*;
#(
   parameter int WIDTH = 64
)
(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [7:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   output logic      [1:0]       avs_response,
   input  wire logic             hub_in_valid,
   input  wire logic [WIDTH-1:0] hub_in_data,
   input  wire logic             hub_in_par_err,
   output logic                  hub_fwd_valid,
   output logic      [WIDTH-1:0] hub_fwd_data,
   output logic                  hub_fwd_poison,
   input  wire logic             core_out_valid,
   input  wire logic [WIDTH-1:0] core_out_data,
   input  wire logic             core_out_par_err,
   output logic                  hub_out_valid,
   output logic      [WIDTH-1:0] hub_out_data,
   output logic                  hub_out_poison,
   output logic                  hub_out_report,
   input  wire logic             buf_in_valid,
   input  wire logic [WIDTH-1:0] buf_in_data,
   input  wire logic             buf_in_par_err,
   output logic                  buf_fwd_valid,
   output logic      [WIDTH-1:0] buf_fwd_data,
   output logic                  buf_fwd_poison,
   input  wire logic             dram_in_valid,
   input  wire logic [WIDTH-1:0] dram_in_data,
   input  wire logic             dram_in_par_err,
   output logic                  dram_fwd_valid,
   output logic      [WIDTH-1:0] dram_fwd_data,
   output logic                  dram_fwd_poison
);

   localparam logic [31:0] HUB_MASK  = 32'h000C_0000;
   localparam logic [31:0] POIS_MASK = 32'h0004_0000;
   localparam logic [1:0]  RSP_OK    = 2'h0;
   localparam logic [1:0]  RSP_DEC   = 2'h3;

   // Refuses a data width that the paths cannot carry.
   if (WIDTH < 1)
   begin : g_width_check
      $error("dpec_top needs WIDTH of at least one");
   end

   // ----------------------------------------------------------------------
   // Bus slave state
   // ----------------------------------------------------------------------
   typedef struct packed
   {
      logic        ack;
      logic [31:0] rdata;
      logic [1:0]  resp;
      logic [1:0]  ecc_mode;
      logic [3:0]  err_seen;
   } dpec_state_t;

   dpec_state_t st_reg;
   dpec_state_t st_next;

   logic [31:0] hub_val;
   logic [31:0] buf_val;
   logic [31:0] dram_val;
   logic        req;
   logic        hub_wr;
   logic        buf_wr;
   logic        dram_wr;
   logic        hub_poison_en;
   logic        hub_stop_en;
   logic        buf_poison_en;
   logic        dram_poison_en;
   logic        buf_mode_ok;
   logic        dram_mode_ok;
   logic        buf_report;
   logic        dram_report;
   logic        hub_in_report;

   assign req     = (avs_read || avs_write) && !st_reg.ack;
   assign hub_wr  = req && avs_write && (avs_address == DPEC_HUB_OFFSET);
   assign buf_wr  = req && avs_write && (avs_address == DPEC_BUF_OFFSET);
   assign dram_wr = req && avs_write && (avs_address == DPEC_DRAM_OFFSET);

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------

   // Hub link register comes out of reset with only poisoning enabled.
   dpec_ctrl_reg #(
      .RESET_VAL (DPEC_HUB_RESET),
      .WR_MASK   (HUB_MASK)
   ) u_hub_reg (
      .core_clk  (core_clk),
      .rst       (rst),
      .wr_en     (hub_wr),
      .byte_en   (avs_byteenable),
      .wr_data   (avs_writedata),
      .value     (hub_val)
   );

   // Buffer register holds only its poison enable; resets to zero.
   dpec_ctrl_reg #(
      .RESET_VAL (DPEC_BUF_RESET),
      .WR_MASK   (POIS_MASK)
   ) u_buf_reg (
      .core_clk  (core_clk),
      .rst       (rst),
      .wr_en     (buf_wr),
      .byte_en   (avs_byteenable),
      .wr_data   (avs_writedata),
      .value     (buf_val)
   );

   // DRAM register holds only its poison enable; resets to zero.
   dpec_ctrl_reg #(
      .RESET_VAL (DPEC_DRAM_RESET),
      .WR_MASK   (POIS_MASK)
   ) u_dram_reg (
      .core_clk  (core_clk),
      .rst       (rst),
      .wr_en     (dram_wr),
      .byte_en   (avs_byteenable),
      .wr_data   (avs_writedata),
      .value     (dram_val)
   );

   assign hub_poison_en  = hub_val[DPEC_POISON_BIT];
   assign hub_stop_en    = hub_val[DPEC_STOP_BIT];

   // Buffer poisoning needs 72-bit or x4 correction mode.
   assign buf_mode_ok    = (st_reg.ecc_mode == DPEC_ECC_72) ||
                           (st_reg.ecc_mode == DPEC_ECC_X4);
   // DRAM poisoning needs 72-bit or x4 correction mode.
   assign dram_mode_ok   = (st_reg.ecc_mode == DPEC_ECC_72) ||
                           (st_reg.ecc_mode == DPEC_ECC_X4);
   assign buf_poison_en  = buf_val[DPEC_POISON_BIT] && buf_mode_ok;
   assign dram_poison_en = dram_val[DPEC_POISON_BIT] && dram_mode_ok;

   // ----------------------------------------------------------------------
   // Data paths
   // ----------------------------------------------------------------------

   // Incoming hub data: poisoned on parity error when enabled.
   dpec_path #(.WIDTH(WIDTH)) u_hub_in (
      .core_clk   (core_clk),
      .rst        (rst),
      .in_valid   (hub_in_valid),
      .in_data    (hub_in_data),
      .in_par_err (hub_in_par_err),
      .poison_en  (hub_poison_en),
      .stop_en    (1'b0),
      .out_valid  (hub_fwd_valid),
      .out_data   (hub_fwd_data),
      .out_poison (hub_fwd_poison),
      .out_report (hub_in_report)
   );

   // Outgoing hub data: propagate, or report only when stop is set.
   dpec_path #(.WIDTH(WIDTH)) u_hub_out (
      .core_clk   (core_clk),
      .rst        (rst),
      .in_valid   (core_out_valid),
      .in_data    (core_out_data),
      .in_par_err (core_out_par_err),
      .poison_en  (1'b1),
      .stop_en    (hub_stop_en),
      .out_valid  (hub_out_valid),
      .out_data   (hub_out_data),
      .out_poison (hub_out_poison),
      .out_report (hub_out_report)
   );

   // Posted write buffer data; clean parity when disabled.
   dpec_path #(.WIDTH(WIDTH)) u_buf (
      .core_clk   (core_clk),
      .rst        (rst),
      .in_valid   (buf_in_valid),
      .in_data    (buf_in_data),
      .in_par_err (buf_in_par_err),
      .poison_en  (buf_poison_en),
      .stop_en    (1'b0),
      .out_valid  (buf_fwd_valid),
      .out_data   (buf_fwd_data),
      .out_poison (buf_fwd_poison),
      .out_report (buf_report)
   );

   // DRAM read data; clean parity when disabled.
   dpec_path #(.WIDTH(WIDTH)) u_dram (
      .core_clk   (core_clk),
      .rst        (rst),
      .in_valid   (dram_in_valid),
      .in_data    (dram_in_data),
      .in_par_err (dram_in_par_err),
      .poison_en  (dram_poison_en),
      .stop_en    (1'b0),
      .out_valid  (dram_fwd_valid),
      .out_data   (dram_fwd_data),
      .out_poison (dram_fwd_poison),
      .out_report (dram_report)
   );

   // ----------------------------------------------------------------------
   // Bus slave and status
   // ----------------------------------------------------------------------

   // One wait cycle per access; reads return masked register images.
   always_comb
   begin
      st_next       = st_reg;
      st_next.ack   = req;
      st_next.rdata = 32'h0000_0000;
      st_next.resp  = RSP_OK;
      // Hardware sets the sticky seen bits; a set wins over a clear.
      if (req && avs_write && (avs_address == DPEC_STAT_OFFSET))
      begin
         st_next.err_seen = st_reg.err_seen & ~avs_writedata[3:0];
      end
      st_next.err_seen = st_next.err_seen |
                         {dram_fwd_poison, buf_fwd_poison,
                          hub_out_report, hub_fwd_poison};
      if (req && avs_write && (avs_address == DPEC_MODE_OFFSET) &&
          avs_byteenable[0])
      begin
         st_next.ecc_mode = avs_writedata[1:0];
      end
      if (req)
      begin
         unique case (avs_address)
            DPEC_HUB_OFFSET:  st_next.rdata = hub_val & HUB_MASK;
            DPEC_BUF_OFFSET:  st_next.rdata = buf_val & POIS_MASK;
            DPEC_DRAM_OFFSET: st_next.rdata = dram_val & POIS_MASK;
            DPEC_MODE_OFFSET: st_next.rdata = {30'h0, st_reg.ecc_mode};
            DPEC_STAT_OFFSET: st_next.rdata = {28'h0, st_reg.err_seen};
            default:          st_next.resp  = RSP_DEC;
         endcase
         if (!avs_read)
         begin
            st_next.rdata = 32'h0000_0000;
         end
      end
   end

   // Slave state register.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '{ack: 1'b0, rdata: 32'h0000_0000, resp: RSP_OK,
                     ecc_mode: DPEC_MODE_RESET, err_seen: 4'h0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
   assign avs_readdata    = st_reg.rdata;
   assign avs_response    = st_reg.resp;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------

   stop_report_a: assert property (@(posedge core_clk) disable iff (rst)
      (core_out_valid && core_out_par_err && hub_stop_en)
      |=> hub_out_report && !hub_out_poison)
      else $error("stopped outgoing error still propagated");

   hub_poison_a: assert property (@(posedge core_clk) disable iff (rst)
      (hub_in_valid && hub_in_par_err && hub_poison_en)
      |=> hub_fwd_poison)
      else $error("hub parity error not poisoned");

   hub_reset_a: assert property (@(posedge core_clk)
      $fell(rst) |-> hub_val == DPEC_HUB_RESET)
      else $error("hub register reset value wrong");

   buf_mode_a: assert property (@(posedge core_clk) disable iff (rst)
      (buf_in_valid && buf_in_par_err && buf_val[DPEC_POISON_BIT]
       && st_reg.ecc_mode == DPEC_ECC_NONE && !$changed(st_reg.ecc_mode))
      |=> !buf_fwd_poison)
      else $error("buffer poisoned outside ECC mode");

   dram_poison_a: assert property (@(posedge core_clk) disable iff (rst)
      (dram_in_valid && dram_in_par_err && dram_poison_en)
      |=> dram_fwd_poison)
      else $error("DRAM parity error not poisoned");

   clean_parity_a: assert property (@(posedge core_clk) disable iff (rst)
      !buf_val[DPEC_POISON_BIT] |=> !buf_fwd_poison)
      else $error("buffer poisoned while disabled");

   reserved_read_a: assert property (@(posedge core_clk) disable iff (rst)
      ($past(req) && $past(avs_read)
       && $past(avs_address) == DPEC_HUB_OFFSET)
      |-> (avs_readdata & ~HUB_MASK) == 32'h0000_0000)
      else $error("reserved hub bits read nonzero");

   bus_answer_a: assert property (@(posedge core_clk) disable iff (rst)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest)
      else $error("read not answered in one cycle");

endmodule // dpec_top

// File: logic/dpec_pkg.sv
package dpec_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0]  DPEC_HUB_OFFSET   = 8'hE4;
   localparam logic [7:0]  DPEC_BUF_OFFSET   = 8'hE8;
   localparam logic [7:0]  DPEC_DRAM_OFFSET  = 8'hEC;
   localparam logic [7:0]  DPEC_MODE_OFFSET  = 8'hF0;
   localparam logic [7:0]  DPEC_STAT_OFFSET  = 8'hF4;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int          DPEC_STOP_BIT     = 19;
   localparam int          DPEC_POISON_BIT   = 18;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [31:0] DPEC_HUB_RESET    = 32'h0004_0000;
   localparam logic [31:0] DPEC_BUF_RESET    = 32'h0000_0000;
   localparam logic [31:0] DPEC_DRAM_RESET   = 32'h0000_0000;
   localparam logic [1:0]  DPEC_MODE_RESET   = 2'h0;

   // ----------------------------------------------------------------------
   // Memory error correction modes held in the controller configuration
   // ----------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      DPEC_ECC_NONE = 2'b00,
      DPEC_ECC_72   = 2'b01,
      DPEC_ECC_X4   = 2'b10,
      DPEC_ECC_RSVD = 2'b11
   } dpec_ecc_t;

endpackage

// File: logic/dpec_path.sv
`timescale 1ns/10ps

// Registered data stage that poisons or reports parity errors, or forwards them unmarked.
module dpec_path
   import dpec_pkg::*;
#(
   parameter int WIDTH = 64
)
(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_par_err,
   input  wire logic             poison_en,
   input  wire logic             stop_en,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_poison,
   output logic                  out_report
);

   // Refuses a data width that the stage cannot hold.
   if (WIDTH < 1)
   begin : g_width_check
      $error("dpec_path needs WIDTH of at least one");
   end

   typedef struct packed
   {
      logic             valid;
      logic [WIDTH-1:0] data;
      logic             poison;
      logic             report;
   } dpec_path_t;

   dpec_path_t st_reg;
   dpec_path_t st_next;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------

   // A bad beat is marked poisoned when enabled; stop turns poison into a
   // report only, and a clear enable forwards clean data.
   always_comb
   begin
      st_next        = st_reg;
      st_next.valid  = in_valid;
      st_next.data   = in_data;
      st_next.poison = in_valid && in_par_err && poison_en && !stop_en;
      st_next.report = in_valid && in_par_err && poison_en && stop_en;
   end

   // Stage register.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign out_valid  = st_reg.valid;
   assign out_data   = st_reg.data;
   assign out_poison = st_reg.poison;
   assign out_report = st_reg.report;

   poison_cause_a: assert property (@(posedge core_clk) disable iff (rst)
      out_poison |-> $past(in_par_err) && $past(poison_en)
         && $past(in_valid) && !$past(stop_en))
      else $error("poison without an enabled parity error");

   clean_forward_a: assert property (@(posedge core_clk) disable iff (rst)
      (in_valid && !poison_en) |=> out_valid && !out_poison && !out_report)
      else $error("data marked while checking is off");

endmodule // dpec_path

// File: logic/dpec_ctrl_reg.sv
`timescale 1ns/10ps

// One control register holding a single writable bit group.
module dpec_ctrl_reg
   import dpec_pkg::*;
#(
   parameter logic [31:0] RESET_VAL = 32'h0000_0000,
   parameter logic [31:0] WR_MASK   = 32'h0004_0000
)
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic [3:0]  byte_en,
   input  wire logic [31:0] wr_data,
   output logic      [31:0] value
);

   typedef struct packed
   {
      logic [31:0] val;
   } dpec_reg_t;

   dpec_reg_t st_reg;
   dpec_reg_t st_next;
   logic [31:0] lane_mask;

   // Only enabled lanes and writable bits change; all other bits keep their value.
   always_comb
   begin
      lane_mask = {{8{byte_en[3]}}, {8{byte_en[2]}},
                   {8{byte_en[1]}}, {8{byte_en[0]}}} & WR_MASK;
      st_next   = st_reg;
      if (wr_en)
      begin
         st_next.val = (st_reg.val & ~lane_mask) | (wr_data & lane_mask);
      end
   end

   // Register stage.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '{val: RESET_VAL};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign value = st_reg.val;

   reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      (value & ~WR_MASK) == 32'h0000_0000)
      else $error("reserved bits read nonzero");

endmodule // dpec_ctrl_reg

// File: bench/dpec_peer.sv
`timescale 1ns/10ps

// Far-side source of hub link, core, buffer and DRAM beats.
module dpec_peer
   import dpec_pkg::*;
#(
   parameter int WIDTH = 64
)
(
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  en,
   output logic      [3:0]            valid,
   output logic      [3:0][WIDTH-1:0] data,
   output logic      [3:0]            par_err
);
   int seed = 71;

   // Launches a random beat on each source in randomly chosen cycles while enabled.
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         valid   <= 4'h0;
         par_err <= 4'h0;
         data    <= '0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            // Idle lines keep changing so stale data never matches.
            data[i]    <= WIDTH'({$random(seed), $random(seed)});
            valid[i]   <= en & 1'($random(seed));
            par_err[i] <= 1'($random(seed));
         end
      end
   end
endmodule // dpec_peer

// File: bench/dpec_top_tb.sv
`timescale 1ns/10ps

`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("wrong value at %0t: %h vs %h", $time, g, e); \
      end \
   end

// Self-checking bench for the poison control block.
module dpec_top_tb
   import dpec_pkg::*;
;
   logic                  core_clk = 1'b0;
   logic                  rst = 1'b1;
   logic [7:0]            avs_address = 8'h00;
   logic                  avs_read = 1'b0;
   logic                  avs_write = 1'b0;
   logic [31:0]           avs_writedata = 32'h0;
   logic [3:0]            avs_byteenable = 4'h0;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic [1:0]            avs_response;
   logic                  peer_en = 1'b0;
   logic                  chk_on = 1'b0;
   logic [3:0]            pv;
   logic [3:0][63:0]      pd;
   logic [3:0]            pe;
   logic [3:0]            fv;
   logic [3:0][63:0]      fd;
   logic [3:0]            fp;
   logic                  f_rep;
   logic [3:0]            e_v;
   logic [3:0][63:0]      e_d;
   logic [3:0]            e_p;
   logic                  e_r;
   logic [31:0]           hub_m = DPEC_HUB_RESET;
   logic [31:0]           buf_m = DPEC_BUF_RESET;
   logic [31:0]           dram_m = DPEC_DRAM_RESET;
   logic [1:0]            mode_m = DPEC_MODE_RESET;
   logic [3:0]            stat_m = 4'h0;
   logic [31:0]           rdata;
   logic [1:0]            rresp;
   int                    n_fail = 0;
   int                    num_checks = 0;
   int                    seed = 71;

   // -------------------------------------------------------------------
   // Clock, design and far side
   // -------------------------------------------------------------------
   always #20 core_clk = ~core_clk;

   dpec_peer #(.WIDTH(64)) peer
   (
      .core_clk(core_clk), .rst(rst), .en(peer_en),
      .valid(pv), .data(pd), .par_err(pe)
   );

   dpec_top #(.WIDTH(64)) dut
   (
      .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response),
      .hub_in_valid(pv[0]), .hub_in_data(pd[0]), .hub_in_par_err(pe[0]),
      .hub_fwd_valid(fv[0]), .hub_fwd_data(fd[0]), .hub_fwd_poison(fp[0]),
      .core_out_valid(pv[1]), .core_out_data(pd[1]),
      .core_out_par_err(pe[1]), .hub_out_valid(fv[1]),
      .hub_out_data(fd[1]), .hub_out_poison(fp[1]), .hub_out_report(f_rep),
      .buf_in_valid(pv[2]), .buf_in_data(pd[2]), .buf_in_par_err(pe[2]),
      .buf_fwd_valid(fv[2]), .buf_fwd_data(fd[2]), .buf_fwd_poison(fp[2]),
      .dram_in_valid(pv[3]), .dram_in_data(pd[3]),
      .dram_in_par_err(pe[3]), .dram_fwd_valid(fv[3]),
      .dram_fwd_data(fd[3]), .dram_fwd_poison(fp[3])
   );

   // -------------------------------------------------------------------
   // Reference model of the data stages
   // -------------------------------------------------------------------
   // Captures each beat with the control state in force at its edge.
   always @(posedge core_clk)
   begin
      e_v    <= pv;
      e_d    <= pd;
      e_p[0] <= pe[0] & hub_m[DPEC_POISON_BIT];
      e_p[1] <= pe[1] & ~hub_m[DPEC_STOP_BIT];
      e_r    <= pv[1] & pe[1] & hub_m[DPEC_STOP_BIT];
      e_p[2] <= pe[2] & buf_m[DPEC_POISON_BIT] & (mode_m inside {1, 2});
      e_p[3] <= pe[3] & dram_m[DPEC_POISON_BIT] & (mode_m inside {1, 2});
   end

   // Compares results mid-cycle, once the registered outputs settle.
   always @(negedge core_clk)
   begin
      if (chk_on)
      begin
         `CHK(fv[0], e_v[0])
         if (e_v[0]) `CHK({fd[0], fp[0]}, {e_d[0], e_p[0]})
         `CHK(f_rep, e_r)
         if (!e_r) `CHK(fv[1], e_v[1])
         if (e_r) `CHK(fp[1], 1'b0)
         // Sticky record of incoming hub, buffer and DRAM poison and of outgoing reports seen so far.
         stat_m = stat_m | {e_v[3] & e_p[3], e_v[2] & e_p[2], e_r,
                            e_v[0] & e_p[0]};
         if (e_v[1] && !e_r) `CHK({fd[1], fp[1]}, {e_d[1], e_p[1]})
         `CHK(fv[3:2], e_v[3:2])
         if (e_v[2]) `CHK({fd[2], fp[2]}, {e_d[2], e_p[2]})
         if (e_v[3]) `CHK({fd[3], fp[3]}, {e_d[3], e_p[3]})
      end
   end

   // -------------------------------------------------------------------
   // Register bus access with model update and checks
   // -------------------------------------------------------------------
   task automatic acc(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      logic [31:0] m;
      logic        mapped;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      mapped = a inside {8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4};
      @(posedge core_clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= !wr;
      // Holds the request until waitrequest is sampled low at a rising edge.
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge core_clk);
      end
      rdata = avs_readdata;
      rresp = avs_response;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      `CHK(rresp, mapped ? 2'h0 : 2'h3)
      if (wr && a == DPEC_HUB_OFFSET)
         hub_m = (hub_m & ~(m & 32'h000C_0000)) | (d & m & 32'h000C_0000);
      if (wr && a == DPEC_BUF_OFFSET)
         buf_m = (buf_m & ~(m & 32'h0004_0000)) | (d & m & 32'h0004_0000);
      if (wr && a == DPEC_DRAM_OFFSET)
         dram_m = (dram_m & ~(m & 32'h0004_0000)) | (d & m & 32'h0004_0000);
      if (wr && a == DPEC_MODE_OFFSET && be[0])
         mode_m = d[1:0];
      if (!wr && a == DPEC_HUB_OFFSET) `CHK(rdata, hub_m)
      if (!wr && a == DPEC_BUF_OFFSET) `CHK(rdata, buf_m)
      if (!wr && a == DPEC_DRAM_OFFSET) `CHK(rdata, dram_m)
      if (!wr && a == DPEC_MODE_OFFSET) `CHK(rdata, {30'h0, mode_m})
      if (!wr && a == DPEC_STAT_OFFSET)
         `CHK(rdata, {28'h0, stat_m})
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Cuts a hung run short.
   initial
   begin
      #(40 * 20000);
      n_fail++;
      tally_and_finish();
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      acc(0, DPEC_HUB_OFFSET, 32'h0, 4'hF);
      acc(0, DPEC_BUF_OFFSET, 32'h0, 4'hF);
      acc(0, DPEC_DRAM_OFFSET, 32'h0, 4'hF);
      acc(0, DPEC_MODE_OFFSET, 32'h0, 4'hF);
      for (int k = 0; k < 3; k++)
      begin
         acc(1, 8'hE4 + 8'(4 * k), 32'hFFFF_FFFF, 4'hF);
         acc(0, 8'hE4 + 8'(4 * k), 32'h0, 4'hF);
      end
      // A write with lane 2 disabled must leave the control bits alone.
      acc(1, DPEC_HUB_OFFSET, 32'h0, 4'hB);
      acc(0, DPEC_HUB_OFFSET, 32'h0, 4'hF);
      acc(1, 8'h40, 32'hFFFF_FFFF, 4'hF);
      acc(0, 8'h40, 32'h0, 4'hF);
      acc(1, DPEC_STAT_OFFSET, 32'h0000_000F, 4'hF);
      chk_on = 1'b1;
      // Sweeps every ECC mode under random control settings.
      for (int i = 0; i < 12; i++)
      begin
         peer_en <= 1'b0;
         repeat (2) @(posedge core_clk);
         acc(1, DPEC_HUB_OFFSET, $random(seed), 4'hF);
         acc(1, DPEC_BUF_OFFSET, $random(seed), 4'hF);
         acc(1, DPEC_DRAM_OFFSET, $random(seed), 4'hF);
         acc(1, DPEC_MODE_OFFSET, 32'(i % 4), 4'h1);
         acc(0, DPEC_HUB_OFFSET, 32'h0, 4'hF);
         peer_en <= 1'b1;
         repeat (40) @(posedge core_clk);
      end
      peer_en <= 1'b0;
      repeat (3) @(posedge core_clk);
      // The sticky record must hold every event of the sweep except outgoing hub poison.
      acc(0, DPEC_STAT_OFFSET, 32'h0, 4'hF);
      tally_and_finish();
   end
endmodule // dpec_top_tb
